// ===== hw/pcb_bank.sv
// configuration register bank of a fractional-n synthesizer, registers 6 to 12
// assumes serial pins and reference arrive asynchronously to mclk
`timescale 1ns/100ps
module pcb_bank
    import pcb_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic serial_clk_pin, // serial clock pin
    input wire logic serial_data_pin, // serial data pin
    input wire logic load_strobe, // load pin, rising edge loads
    input wire logic ref_pin, // reference input pin
    input wire logic compare_tick, // one-cycle pulse per compare period
    input wire logic window_ok, // phase error inside lock window
    input wire logic ref_present, // reference activity seen
    output pcb_output_type out_cfg, // output stage controls
    output pcb_lock_type lock_cfg, // lock detector controls
    output pcb_cal_type cal_cfg, // calibration controls
    output logic primary_output_on, // primary stage supply
    output logic auxiliary_output_on, // auxiliary stage supply
    output logic locked, // digital lock detect
    output logic adc_clk_tick, // converter clock enable pulse
    output logic conversion_start, // one-cycle pulse
    output logic freq_apply, // one-cycle pulse, register 0 written
    output logic [31:0] freq_word // last register 0 word
);
    // ========================================================
    // pin synchronisers
    logic [1:0] sclk_sync; // two flops each
    logic [1:0] sdat_sync;
    logic [1:0] load_sync;
    logic [1:0] ref_sync;
    logic sclk_last; // edge history from second flops
    logic load_last;
    logic ref_last;
    logic sclk_rise;
    logic load_rise;
    logic ref_rise;

    // synchronise pins, then take edges from second stage only
    always_ff @(posedge mclk) begin
        if (reset) begin
            sclk_sync <= 2'h0;
            sdat_sync <= 2'h0;
            load_sync <= 2'h0;
            ref_sync <= 2'h0;
            sclk_last <= 1'b0;
            load_last <= 1'b0;
            ref_last <= 1'b0;
        end else begin
            sclk_sync <= {sclk_sync[0], serial_clk_pin};
            sdat_sync <= {sdat_sync[0], serial_data_pin};
            load_sync <= {load_sync[0], load_strobe};
            ref_sync <= {ref_sync[0], ref_pin};
            sclk_last <= sclk_sync[1];
            load_last <= load_sync[1];
            ref_last <= ref_sync[1];
        end
    end

    assign sclk_rise = sclk_sync[1] && !sclk_last;
    assign load_rise = load_sync[1] && !load_last;
    assign ref_rise = ref_sync[1] && !ref_last;

    // ========================================================
    // serial receiver
    logic [31:0] word; // shifted word
    logic word_valid; // one-cycle

    pcb_shift_in shifter (
        .mclk(mclk),
        .reset(reset),
        .sclk_rise(sclk_rise),
        .sdata(sdat_sync[1]),
        .load_rise(load_rise),
        .word(word),
        .word_valid(word_valid)
    );

    // ========================================================
    // load gating: optionally wait for the next reference rise
    logic pending; // word waiting for reference edge
    logic next_pending;
    logic commit; // word enters its register now

    always_comb begin
        next_pending = pending;
        commit = 1'b0;
        if (word_valid && lock_cfg.load_sync) begin
            next_pending = 1'b1;
        end else if (word_valid) begin
            commit = 1'b1;
        end else if (pending && ref_rise) begin
            next_pending = 1'b0;
            commit = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            pending <= 1'b0;
        end else begin
            pending <= next_pending;
        end
    end

    // ========================================================
    // register decode and storage
    function automatic logic pcb_hit(input logic [31:0] w, input logic [3:0] sel);
        pcb_hit = (w[3:0] == sel);
    endfunction

    // precision code or fixed mode to window width
    function automatic logic [7:0] pcb_window(input logic kind, input logic [1:0] sel);
        if (kind) begin
            pcb_window = PCB_WIN_FIXED;
        end else begin
            unique case (sel)
                2'h0: pcb_window = PCB_WIN_0;
                2'h1: pcb_window = PCB_WIN_1;
                2'h2: pcb_window = PCB_WIN_2;
                2'h3: pcb_window = PCB_WIN_3;
            endcase
        end
    endfunction

    pcb_output_type next_out_cfg;
    pcb_lock_type next_lock_cfg;
    pcb_cal_type next_cal_cfg;
    logic next_conversion_start;
    logic next_freq_apply;
    logic [31:0] next_freq_word;

    // field extraction per selected register
    always_comb begin
        next_out_cfg = out_cfg;
        next_lock_cfg = lock_cfg;
        next_cal_cfg = cal_cfg;
        next_conversion_start = 1'b0;
        next_freq_apply = 1'b0;
        next_freq_word = freq_word;
        if (commit) begin
            if (pcb_hit(word, PCB_SEL_OUTPUT)) begin
                next_out_cfg.bleed_level = word[PCB_BLEED_LSB +: 8];
                next_out_cfg.mute_until_lock = word[PCB_MUTE_BIT];
                next_out_cfg.aux_en = word[PCB_AUX_EN_BIT];
                next_out_cfg.aux_pwr = word[PCB_AUX_PWR_LSB +: 2];
                next_out_cfg.pri_en = word[PCB_PRI_EN_BIT];
                next_out_cfg.pri_pwr = word[PCB_PRI_PWR_LSB +: 2];
            end
            if (pcb_hit(word, PCB_SEL_LOCK)) begin
                next_lock_cfg.load_sync = word[PCB_SYNC_BIT];
                next_lock_cfg.lock_count_sel = word[PCB_LCOUNT_LSB +: 2];
                next_lock_cfg.reference_loss_mode = word[PCB_LOSS_BIT];
                next_lock_cfg.lock_window_tenths = pcb_window(word[PCB_LKIND_BIT],
                    word[PCB_LWIN_LSB +: 2]);
            end
            if (pcb_hit(word, PCB_SEL_CAL)) begin
                next_cal_cfg.band_div = word[PCB_BAND_LSB +: 8];
                next_cal_cfg.band_select_timeout = word[PCB_TIMEOUT_LSB +: 10];
                next_cal_cfg.level_cal_wait = word[PCB_LEVEL_LSB +: 5];
                next_cal_cfg.settle_wait = word[PCB_SETTLE_LSB +: 5];
            end
            if (pcb_hit(word, PCB_SEL_ADC)) begin
                next_cal_cfg.adc_div = word[PCB_ADCDIV_LSB +: 8];
                next_cal_cfg.conversion_on_write = word[PCB_CONV_BIT];
                next_cal_cfg.converter_power = word[PCB_APWR_BIT];
                next_conversion_start = word[PCB_CONV_BIT] && word[PCB_APWR_BIT];
            end
            if (pcb_hit(word, PCB_SEL_RESYNC)) begin
                next_cal_cfg.resync_timeout = word[PCB_RESYNC_LSB +: 16];
            end
            if (pcb_hit(word, PCB_SEL_FREQ)) begin
                next_freq_word = word;
                next_freq_apply = 1'b1;
            end
        end
    end

    // registers only
    always_ff @(posedge mclk) begin
        if (reset) begin
            out_cfg <= '0;
            lock_cfg <= '0;
            cal_cfg <= '0;
            cal_cfg.adc_div <= PCB_ADCDIV_RESET;
            lock_cfg.lock_window_tenths <= PCB_WIN_0;
            conversion_start <= 1'b0;
            freq_apply <= 1'b0;
            freq_word <= PCB_RESET_WORD;
        end else begin
            out_cfg <= next_out_cfg;
            lock_cfg <= next_lock_cfg;
            cal_cfg <= next_cal_cfg;
            conversion_start <= next_conversion_start;
            freq_apply <= next_freq_apply;
            freq_word <= next_freq_word;
        end
    end

    // ========================================================
    // lock detector
    pcb_lock_watch watcher (
        .mclk(mclk),
        .reset(reset),
        .ref_rise(compare_tick),
        .window_ok(window_ok),
        .ref_present(ref_present),
        .lock_count_sel(lock_cfg.lock_count_sel),
        .reference_loss_mode(lock_cfg.reference_loss_mode),
        .locked(locked)
    );

    // output stage supply gated by mute until lock
    always_comb begin
        primary_output_on = out_cfg.pri_en && (!out_cfg.mute_until_lock || locked);
        auxiliary_output_on = out_cfg.aux_en && (!out_cfg.mute_until_lock || locked);
    end

    // ========================================================
    // converter clock divider, counted in compare ticks
    logic [7:0] adc_count; // ticks since last pulse
    logic [7:0] next_adc_count;
    logic next_adc_clk_tick;

    always_comb begin
        next_adc_count = adc_count;
        next_adc_clk_tick = 1'b0;
        if (!cal_cfg.converter_power) begin
            next_adc_count = 8'h00;
        end else if (compare_tick) begin
            if (adc_count + 8'h01 >= cal_cfg.adc_div) begin
                next_adc_count = 8'h00;
                next_adc_clk_tick = 1'b1;
            end else begin
                next_adc_count = adc_count + 8'h01;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            adc_count <= 8'h00;
            adc_clk_tick <= 1'b0;
        end else begin
            adc_count <= next_adc_count;
            adc_clk_tick <= next_adc_clk_tick;
        end
    end

    // ========================================================
    // checks
    sequence pcb_sync_wait_s;
        word_valid && lock_cfg.load_sync;
    endsequence

    sync_hold_a: assert property (@(posedge mclk) disable iff (reset)
        pcb_sync_wait_s |=> pending)
        else $error("sync load not held for reference");
    mute_gate_a: assert property (@(posedge mclk) disable iff (reset)
        (out_cfg.mute_until_lock && !locked) |-> !primary_output_on && !auxiliary_output_on)
        else $error("output on before lock");
    route_cal_a: assert property (@(posedge mclk) disable iff (reset)
        (commit && word[3:0] == PCB_SEL_CAL) |=> cal_cfg.band_div == $past(word[31:24]))
        else $error("register 9 not routed");
    bleed_load_a: assert property (@(posedge mclk) disable iff (reset)
        (commit && word[3:0] == PCB_SEL_OUTPUT) |=> out_cfg.bleed_level == $past(word[20:13]))
        else $error("bleed level not loaded");
    freq_only_a: assert property (@(posedge mclk) disable iff (reset)
        freq_apply |-> $past(commit) && $past(word[3:0]) == PCB_SEL_FREQ)
        else $error("frequency applied without register 0");
    conv_start_a: assert property (@(posedge mclk) disable iff (reset)
        (commit && word[3:0] == PCB_SEL_ADC && word[5] && word[4]) |=> conversion_start)
        else $error("no conversion on register 10 write");
    window_fix_a: assert property (@(posedge mclk) disable iff (reset)
        (commit && word[3:0] == PCB_SEL_LOCK && word[4])
        |=> lock_cfg.lock_window_tenths == PCB_WIN_FIXED)
        else $error("fixed window not applied");
    resync_load_a: assert property (@(posedge mclk) disable iff (reset)
        (commit && word[3:0] == PCB_SEL_RESYNC) |=> cal_cfg.resync_timeout == $past(word[31:16]))
        else $error("resync timeout not loaded");
endmodule

// ===== shared/pcb_pkg.sv
// constants, field layouts and carrier structs of the synthesizer register bank
// assumes one 25 MHz clock and a synchronous active-high reset
package pcb_pkg;
    // ========================================================
    // register selects (low four bits of each word)
    localparam logic [3:0] PCB_SEL_OUTPUT = 4'h6;
    localparam logic [3:0] PCB_SEL_LOCK = 4'h7;
    localparam logic [3:0] PCB_SEL_FIXED_A = 4'h8;
    localparam logic [3:0] PCB_SEL_CAL = 4'h9;
    localparam logic [3:0] PCB_SEL_ADC = 4'hA;
    localparam logic [3:0] PCB_SEL_FIXED_B = 4'hB;
    localparam logic [3:0] PCB_SEL_RESYNC = 4'hC;
    localparam logic [3:0] PCB_SEL_FREQ = 4'h0;
    // ========================================================
    // field positions
    localparam int PCB_BLEED_LSB = 13;
    localparam int PCB_MUTE_BIT = 11;
    localparam int PCB_AUX_EN_BIT = 9;
    localparam int PCB_AUX_PWR_LSB = 7;
    localparam int PCB_PRI_EN_BIT = 6;
    localparam int PCB_PRI_PWR_LSB = 4;
    localparam int PCB_SYNC_BIT = 25;
    localparam int PCB_LCOUNT_LSB = 8;
    localparam int PCB_LOSS_BIT = 7;
    localparam int PCB_LWIN_LSB = 5;
    localparam int PCB_LKIND_BIT = 4;
    localparam int PCB_BAND_LSB = 24;
    localparam int PCB_TIMEOUT_LSB = 14;
    localparam int PCB_LEVEL_LSB = 9;
    localparam int PCB_SETTLE_LSB = 4;
    localparam int PCB_ADCDIV_LSB = 6;
    localparam int PCB_CONV_BIT = 5;
    localparam int PCB_APWR_BIT = 4;
    localparam int PCB_RESYNC_LSB = 16;
    // ========================================================
    // values after reset and fixed words
    localparam logic [31:0] PCB_RESET_WORD = 32'h0000_0000;
    localparam logic [7:0] PCB_ADCDIV_RESET = 8'h01;
    localparam logic [31:0] PCB_FIXED_A_WORD = 32'h102D_0428;
    localparam logic [31:0] PCB_FIXED_B_WORD = 32'h0061_300B;
    localparam int PCB_WORD_BITS = 32;
    // ========================================================
    // lock window in tenths of ns, by precision code, and fixed window
    localparam logic [7:0] PCB_WIN_0 = 8'h32;
    localparam logic [7:0] PCB_WIN_1 = 8'h3C;
    localparam logic [7:0] PCB_WIN_2 = 8'h50;
    localparam logic [7:0] PCB_WIN_3 = 8'h78;
    localparam logic [7:0] PCB_WIN_FIXED = 8'h1D;

    // output stage controls
    typedef struct packed {
        logic [7:0] bleed_level;
        logic mute_until_lock;
        logic aux_en;
        logic [1:0] aux_pwr;
        logic pri_en;
        logic [1:0] pri_pwr;
    } pcb_output_type;

    // lock detector controls
    typedef struct packed {
        logic load_sync;
        logic [1:0] lock_count_sel;
        logic reference_loss_mode;
        logic [7:0] lock_window_tenths;
    } pcb_lock_type;

    // calibration controls
    typedef struct packed {
        logic [7:0] band_div;
        logic [9:0] band_select_timeout;
        logic [4:0] level_cal_wait;
        logic [4:0] settle_wait;
        logic [7:0] adc_div;
        logic conversion_on_write;
        logic converter_power;
        logic [15:0] resync_timeout;
    } pcb_cal_type;
endpackage

// ===== hw/pcb_shift_in.sv
// serial word receiver: shifts data msb first on serial clock rising edges
// assumes pins already passed through two-flop synchronisers
`timescale 1ns/100ps
module pcb_shift_in
    import pcb_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic sclk_rise, // one-cycle pulse
    input wire logic sdata, // synchronised data pin
    input wire logic load_rise, // one-cycle pulse
    output logic [31:0] word, // last word shifted
    output logic word_valid // one-cycle pulse
);
    // ========================================================
    // shift register
    logic [31:0] shift; // collecting bits
    logic [31:0] next_shift;
    logic [31:0] next_word;
    logic next_word_valid;

    // next value of shifter and captured word
    always_comb begin
        next_shift = shift;
        next_word = word;
        next_word_valid = 1'b0;
        if (sclk_rise) begin
            next_shift = {shift[30:0], sdata};
        end
        if (load_rise) begin
            next_word = shift;
            next_word_valid = 1'b1;
        end
    end

    // registers only
    always_ff @(posedge mclk) begin
        if (reset) begin
            shift <= PCB_RESET_WORD;
            word <= PCB_RESET_WORD;
            word_valid <= 1'b0;
        end else begin
            shift <= next_shift;
            word <= next_word;
            word_valid <= next_word_valid;
        end
    end

    // ========================================================
    // checks
    load_capture_a: assert property (@(posedge mclk) disable iff (reset)
        load_rise |=> (word == $past(shift)) && word_valid)
        else $error("word not captured on load");
endmodule

// ===== hw/pcb_lock_watch.sv
// lock detector: counts consecutive in-window reference cycles
// assumes ref_rise and window_ok are synchronised single-cycle inputs
`timescale 1ns/100ps
module pcb_lock_watch
    import pcb_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic ref_rise, // one-cycle pulse per reference cycle
    input wire logic window_ok, // phase error inside window this cycle
    input wire logic ref_present, // reference still toggling
    input wire logic [1:0] lock_count_sel,
    input wire logic reference_loss_mode,
    output logic locked
);
    // ========================================================
    // target count by selector, shared decode
    function automatic logic [11:0] pcb_count_target(input logic [1:0] sel);
        unique case (sel)
            2'h0: pcb_count_target = 12'h400;
            2'h1: pcb_count_target = 12'h800;
            2'h2: pcb_count_target = 12'hC00;
            2'h3: pcb_count_target = 12'hFFF;
        endcase
    endfunction

    logic [11:0] count; // consecutive good cycles
    logic [11:0] next_count;
    logic next_locked;

    // count good cycles, drop on a miss or lost reference
    always_comb begin
        next_count = count;
        next_locked = locked;
        if (reference_loss_mode && !ref_present) begin
            next_count = 12'h000;
            next_locked = 1'b0;
        end else if (ref_rise) begin
            if (!window_ok) begin
                next_count = 12'h000;
                next_locked = 1'b0;
            end else if (count >= pcb_count_target(lock_count_sel) - 12'h001) begin
                next_locked = 1'b1;
            end else begin
                next_count = count + 12'h001;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            count <= 12'h000;
            locked <= 1'b0;
        end else begin
            count <= next_count;
            locked <= next_locked;
        end
    end

    // ========================================================
    // checks
    miss_unlock_a: assert property (@(posedge mclk) disable iff (reset)
        (ref_rise && !window_ok && !(reference_loss_mode && !ref_present)) |=> !locked)
        else $error("lock held after miss");
    loss_unlock_a: assert property (@(posedge mclk) disable iff (reset)
        (reference_loss_mode && !ref_present) |=> !locked && count == 12'h000)
        else $error("lock held without reference");
endmodule

// ===== dv/pcb_host_model.sv
// host controller model driving the three-wire serial port
// assumes mclk at 25 MHz; serial clock stands low between words
`timescale 1ns/100ps
module pcb_host_model (
    input wire logic mclk,
    output logic sclk,
    output logic sdata,
    output logic load
);
    // ==========================================
    // idle levels at time zero
    initial begin
        sclk = 1'b0;
        sdata = 1'b0;
        load = 1'b0;
    end
    // 32 bits msb first, sclk 4 mclk low then 3 mclk high per bit, then load rise
    task automatic send(input logic [31:0] w);
        for (int i = 31; i >= 0; i--) begin
            @(posedge mclk) sdata <= w[i];
            repeat (3) @(posedge mclk);
            sclk <= 1'b1;
            repeat (3) @(posedge mclk);
            sclk <= 1'b0;
        end
        repeat (3) @(posedge mclk);
        sdata <= ~w[0]; // released line shows no stale bit
        load <= 1'b1;
        repeat (4) @(posedge mclk);
        load <= 1'b0;
    endtask
endmodule

// ===== dv/testbench.sv
// self-checking bench of the register bank
// assumes the host model as serial master; one 25 MHz clock
`timescale 1ns/100ps
module testbench;
    import pcb_pkg::*;
    logic mclk = 0, reset = 1, ref_pin = 0, ref_run = 1, compare_tick = 0;
    logic window_ok = 0, ref_present = 1;
    logic serial_clk_pin, serial_data_pin, load_strobe;
    pcb_output_type out_cfg, eo;
    pcb_lock_type lock_cfg, el;
    pcb_cal_type cal_cfg, ec;
    logic primary_output_on, auxiliary_output_on, locked, adc_clk_tick;
    logic conversion_start, freq_apply;
    logic [31:0] freq_word, w, r;
    logic [31:0] fq[$]; // expected register 0 words
    logic [7:0] wt[4] = '{PCB_WIN_0, PCB_WIN_1, PCB_WIN_2, PCB_WIN_3};
    int n_mismatch = 0, checks = 0, n_conv = 0, n_conv_exp = 0, i;
    always #20 mclk = ~mclk;
    pcb_host_model host (.mclk, .sclk(serial_clk_pin), .sdata(serial_data_pin),
        .load(load_strobe));
    pcb_bank dut (.mclk, .reset, .serial_clk_pin, .serial_data_pin, .load_strobe,
        .ref_pin, .compare_tick, .window_ok, .ref_present, .out_cfg, .lock_cfg,
        .cal_cfg, .primary_output_on, .auxiliary_output_on, .locked, .adc_clk_tick,
        .conversion_start, .freq_apply, .freq_word);
    // ==========================================
    // compare tick every other cycle, free reference
    always @(posedge mclk) begin
        compare_tick <= ~compare_tick;
        if (ref_run) ref_pin <= ~ref_pin;
    end
    // watcher: pops the oldest expected word on each apply pulse
    always @(posedge mclk) begin
        if (conversion_start === 1'b1) n_conv++;
        if (freq_apply === 1'b1) begin
            if (fq.size() == 0) chk(0, 1);
            else chk(freq_word, fq.pop_front());
        end
    end
    task automatic chk(input logic [63:0] s, input logic [63:0] e);
        checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("[ERR] %0t got %0h expected %0h", $time, s, e);
        end
    endtask
    // write a word, then compare all three register groups
    task automatic wr(input logic [31:0] v);
        host.send(v);
        repeat (10) @(posedge mclk);
        chk(out_cfg, eo);
        chk(lock_cfg, el);
        chk(cal_cfg, ec);
    endtask
    task automatic close_out();
        $display("counts: checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // watchdog
    initial begin
        #(40 * 60000);
        n_mismatch++;
        close_out();
    end
    // ==========================================
    // main sequence
    initial begin
        void'($urandom(32'h7DE62EB7));
        ec = '0;
        ec.adc_div = PCB_ADCDIV_RESET;
        eo = '0;
        el = '0;
        el.lock_window_tenths = PCB_WIN_0;
        repeat (8) @(posedge mclk);
        reset <= 1'b0;
        repeat (2) @(posedge mclk);
        chk(cal_cfg, ec);
        chk(lock_cfg, el);
        $display("test reset done");
        // descending start-up order, registers 12 to 6, then an unmapped register 3
        r = $urandom();
        ec.resync_timeout = r[15:0];
        wr({r[15:0], 12'h041, 4'hC});
        wr(PCB_FIXED_B_WORD);
        ec.adc_div = 8'h03;
        ec.conversion_on_write = 1'b1;
        ec.converter_power = 1'b1;
        n_conv_exp++;
        wr(32'h00C0_00FA);
        i = 0;
        while (adc_clk_tick !== 1'b1 && i < 100) begin @(negedge mclk); i++; end
        i = 1;
        @(negedge mclk);
        while (adc_clk_tick !== 1'b1 && i < 100) begin @(negedge mclk); i++; end
        chk(i, 6);
        // top bits forced so band clock and calibration products stay in range
        w = {$urandom()} & 32'hFFFF_FFF0 | 32'h8080_2109;
        {ec.band_div, ec.band_select_timeout, ec.level_cal_wait, ec.settle_wait} = w[31:4];
        wr(w);
        wr(PCB_FIXED_A_WORD);
        for (int k = 0; k < 5; k++) begin
            r = $urandom();
            el = {1'b0, r[1:0], r[2], (k == 4) ? PCB_WIN_FIXED : wt[k[1:0]]};
            wr({6'b000100, 16'h0, r[1:0], r[2], k[1:0], k == 4, 4'h7});
        end
        el = {4'h0, PCB_WIN_3};
        wr(32'h1000_0067);
        w = {$urandom()} & 32'hFFFF_E3F0 | 32'h6;
        eo = {w[20:13], w[11], w[9], w[8:7], w[6], w[5:4]};
        wr(w);
        chk(primary_output_on, w[6]);
        chk(auxiliary_output_on, w[9]);
        wr({$urandom()} & 32'hFFFF_FFF0 | 32'h3);
        $display("test register writes done");
        // mute until lock
        eo = {8'h00, 1'b1, 1'b1, 2'b00, 1'b1, 2'b00};
        wr(32'h0000_0A46);
        chk(primary_output_on, 1'b0);
        window_ok <= 1'b1;
        i = 0;
        while (locked !== 1'b1 && i < 3000) begin @(negedge mclk); i++; end
        chk(locked, 1'b1);
        // 1024 good compare ticks at two cycles each
        chk(i >= 2040 && i <= 2060, 1'b1);
        chk(primary_output_on, 1'b1);
        chk(auxiliary_output_on, 1'b1);
        // lock dropped when the reference goes away in loss mode
        el = {1'b0, 2'b00, 1'b1, PCB_WIN_3};
        wr(32'h1000_00E7);
        chk(locked, 1'b1);
        ref_present <= 1'b0;
        repeat (2) @(posedge mclk);
        chk(locked, 1'b0);
        chk(primary_output_on, 1'b0);
        ref_present <= 1'b1;
        $display("test mute until lock done");
        // load held until a reference rise
        el = {1'b1, 2'b00, 1'b0, PCB_WIN_3};
        wr(32'h1200_0067);
        ref_run <= 1'b0;
        host.send(32'h0000_0076);
        repeat (12) @(posedge mclk);
        chk(out_cfg, eo);
        ref_run <= 1'b1;
        repeat (12) @(posedge mclk);
        eo = {8'h00, 1'b0, 1'b0, 2'b00, 1'b1, 2'b11};
        chk(out_cfg, eo);
        $display("test load sync done");
        // frequency word after the converter wait
        repeat (6 * 17) @(posedge mclk);
        w = {$urandom()} & 32'hFFFF_FFF0;
        fq.push_back(w);
        wr(w);
        chk(fq.size(), 0);
        chk(n_conv, n_conv_exp);
        $display("test frequency apply done");
        close_out();
    end
endmodule
